// >>> design/rdm_defines.vh
// constants for the rs-485 direction and multidrop block
// assumes a 50 MHz clk and an 8-bit character with a ninth parity/address bit
`ifndef RDM_DEFINES_VH
`define RDM_DEFINES_VH
// extra_feature_ctrl_reg bit positions
`define RDM_EXTRA_FEATURE_CTRL_REG_MULTIDROP 0
`define RDM_EXTRA_FEATURE_CTRL_REG_AUTO_DIR 4
`define RDM_EXTRA_FEATURE_CTRL_REG_DIR_INV 5
// enhanced_feature_reg bit position
`define RDM_EFR_SPECIAL 5
// modem_control_reg bit position
`define RDM_MCR_RTS 1
// interrupt_enable_reg bit position
`define RDM_IER_LINE 2
// line_status_reg bit position for parity error
`define RDM_LSR_PARITY 2
// fifo geometry
`define RDM_FIFO_WIDTH 9
`define RDM_FIFO_DEPTH 16
`define RDM_FIFO_AW 4
// reset values
`define RDM_RTS_IDLE 1'b1
`endif

// >>> design/rdm_fifo.v
// synchronous fifo with valid/ready on both sides
// assumes a single clock and synchronous active-high reset
`timescale 1ns/1ps
`include "rdm_defines.vh"
module rdm_fifo #(
	parameter WIDTH = `RDM_FIFO_WIDTH,
	parameter DEPTH = `RDM_FIFO_DEPTH,
	parameter AW = `RDM_FIFO_AW
) (
	input wire clk, // system clock
	input wire rst, // synchronous reset
	input wire in_valid, // write request
	output wire in_ready, // space available
	input wire [WIDTH-1:0] in_data, // write data
	output wire out_valid, // data available
	input wire out_ready, // consumer accepts
	output wire [WIDTH-1:0] out_data, // head word
	output wire empty, // nothing stored
	output wire full // no room left
);
	// ==========================================
	// storage and pointers
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire do_wr;
	wire do_rd;
	assign full = (count_r == DEPTH[AW:0]);
	assign empty = (count_r == {(AW+1){1'b0}});
	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign out_data = mem[rd_ptr_r];
	assign do_wr = in_valid & ~full;
	assign do_rd = out_ready & ~empty;
	// pointers wrap naturally; depth must be a power of two
	always @(posedge clk) begin
		if (rst) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			if (do_wr & ~do_rd) begin
				count_r <= count_r + 1'b1;
			end else if (do_rd & ~do_wr) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
	// memory write has no reset
	always @(posedge clk) begin
		if (do_wr) begin
			mem[wr_ptr_r] <= in_data;
		end
	end
endmodule

// >>> design/rdm_rts_ctrl.v
// rts direction control: manual, flow-control or transmitter-driven
// assumes tx busy status from the transmitter, synchronous to clk
`timescale 1ns/1ps
`include "rdm_defines.vh"
module rdm_rts_ctrl (
	input wire clk, // system clock
	input wire rst, // synchronous reset
	input wire auto_dir, // auto direction enable
	input wire dir_inv, // invert rts in auto mode
	input wire mcr_rts, // modem control rts bit
	input wire hw_flow_en, // hardware flow control on
	input wire hw_flow_rts, // rts from flow control
	input wire tx_write, // host write into tx fifo
	input wire tx_fifo_empty, // tx fifo empty
	input wire tx_shift_empty, // shift register empty after stop bit
	output reg rts_n_r // rts pin level
);
	// ==========================================
	// transmit activity tracking
	reg tx_active_r;
	reg rts_nxt;
	// a write wins over completion so a fresh byte never drops rts
	always @(posedge clk) begin
		if (rst) begin
			tx_active_r <= 1'b0;
		end else if (tx_write) begin
			tx_active_r <= 1'b1;
		end else if (tx_fifo_empty & tx_shift_empty) begin
			tx_active_r <= 1'b0;
		end
	end
	// pin select; auto mode takes precedence over both other sources
	always @* begin
		if (auto_dir) begin
			rts_nxt = (tx_active_r | tx_write) ? dir_inv : ~dir_inv;
		end else if (hw_flow_en) begin
			rts_nxt = hw_flow_rts;
		end else begin
			rts_nxt = ~mcr_rts;
		end
	end
	always @(posedge clk) begin
		if (rst) begin
			rts_n_r <= `RDM_RTS_IDLE;
		end else begin
			rts_n_r <= rts_nxt;
		end
	end
endmodule

// >>> design/rdm_top.v
// rs-485 support block: rts direction control and multidrop receive filter
// assumes receiver delivers one 9-bit character per rx_valid pulse;
// the ninth bit is the received parity (address) bit
`timescale 1ns/1ps
`include "rdm_defines.vh"
// Overview of operation
// - Auto direction off: rts follows modem control bit or flow control logic.
// - Auto direction bit hands rts to transmitter, overriding other sources.
// - Auto mode: rts low on tx fifo write, high after last bit.
// - Inversion bit flips auto rts: high while sending, low when done.
// - Multidrop bit selects 9-bit mode; parity one marks an address.
// - Normal multidrop, receiver disabled: drop data bytes until an address.
// - Normal multidrop address: parity error, stored, line interrupt if enabled.
// - Enabled receiver takes everything; further addresses flag parity error.
// - Special detect: compare addresses to match char, discard the rest.
// - Matching address enables receiver, stored with parity bit, interrupts.
// - Auto detect: later mismatching address disables receiver, not stored.
// - Auto detect: later matching address stored, parity bit in status.
module rdm_top #(
	parameter FIFO_DEPTH = `RDM_FIFO_DEPTH,
	parameter FIFO_AW = `RDM_FIFO_AW
) (
	input wire clk, // 50 MHz system clock
	input wire rst, // synchronous active-high reset
	input wire [7:0] extra_feature_ctrl_reg, // direction and multidrop control
	input wire [7:0] enhanced_feature_reg, // special character detect
	input wire [7:0] modem_control_reg, // manual rts
	input wire [7:0] interrupt_enable_reg, // line status interrupt enable
	input wire [7:0] address_match_char, // station address to match
	input wire hw_flow_en, // hardware flow control enabled
	input wire hw_flow_rts, // rts level from flow control logic
	input wire tx_write, // host writes tx fifo, one pulse
	input wire tx_fifo_empty, // tx fifo empty
	input wire tx_shift_empty, // tx shift register idle
	input wire rx_valid, // received character strobe
	input wire [7:0] rx_data, // received character
	input wire rx_par_bit, // received ninth (parity) bit
	input wire rx_par_err, // parity error from normal check
	output wire rx_ready, // receiver may deliver
	input wire rx_en_set, // host enables receiver, pulse
	input wire rx_en_clr, // host disables receiver, pulse
	output reg rx_enabled_r, // receiver enable state
	output reg fifo_valid_r, // rx fifo head valid
	input wire fifo_pop, // host reads rx fifo head
	output reg [7:0] fifo_data_r, // rx fifo head character
	output reg fifo_lsr_par_r, // line status parity bit of head
	output reg line_irq_r, // line status interrupt, level
	input wire line_irq_clr, // host read of line status, pulse
	output reg rts_n_r, // rts pin
	output reg dropped_r // last character was discarded, pulse
);
	// ==========================================
	// control bit decode
	wire multidrop;
	wire special;
	wire auto_dir;
	wire dir_inv;
	wire line_ie;
	assign multidrop = extra_feature_ctrl_reg[`RDM_EXTRA_FEATURE_CTRL_REG_MULTIDROP];
	assign special = enhanced_feature_reg[`RDM_EFR_SPECIAL];
	assign auto_dir = extra_feature_ctrl_reg[`RDM_EXTRA_FEATURE_CTRL_REG_AUTO_DIR];
	assign dir_inv = extra_feature_ctrl_reg[`RDM_EXTRA_FEATURE_CTRL_REG_DIR_INV];
	assign line_ie = interrupt_enable_reg[`RDM_IER_LINE];

	// ==========================================
	// rts direction
	wire rts_n_w;
	rdm_rts_ctrl u_rts (
		.clk(clk),
		.rst(rst),
		.auto_dir(auto_dir),
		.dir_inv(dir_inv),
		.mcr_rts(modem_control_reg[`RDM_MCR_RTS]),
		.hw_flow_en(hw_flow_en),
		.hw_flow_rts(hw_flow_rts),
		.tx_write(tx_write),
		.tx_fifo_empty(tx_fifo_empty),
		.tx_shift_empty(tx_shift_empty),
		.rts_n_r(rts_n_w)
	);
	// registered again so the top output stays a flop
	always @(posedge clk) begin
		if (rst) begin
			rts_n_r <= `RDM_RTS_IDLE;
		end else begin
			rts_n_r <= rts_n_w;
		end
	end

	// ==========================================
	// receive filter
	wire is_addr;
	wire addr_match;
	reg store;
	reg store_par;
	reg en_set_hw;
	reg en_clr_hw;
	reg irq_evt;
	assign is_addr = rx_par_bit;
	assign addr_match = (rx_data == address_match_char);

	// decide fate of each character; back-pressure holds rx while fifo full
	always @* begin
		store = 1'b0;
		store_par = rx_par_err;
		en_set_hw = 1'b0;
		en_clr_hw = 1'b0;
		irq_evt = 1'b0;
		if (rx_valid & rx_ready) begin
			if (!multidrop) begin
				store = 1'b1;
				irq_evt = rx_par_err;
			end else if (special) begin
				if (is_addr & addr_match) begin
					store = 1'b1;
					store_par = 1'b1;
					en_set_hw = ~rx_enabled_r;
					irq_evt = 1'b1;
				end else if (is_addr) begin
					en_clr_hw = 1'b1;
				end else begin
					store = rx_enabled_r;
				end
			end else begin
				if (is_addr) begin
					store = 1'b1;
					store_par = 1'b1;
					irq_evt = 1'b1;
				end else begin
					store = rx_enabled_r;
					store_par = rx_par_err;
				end
			end
		end
	end

	// receiver enable: host set/clear plus automatic address control
	// hardware enable wins over a coincident host clear; it fires only while the receiver is disabled
	always @(posedge clk) begin
		if (rst) begin
			rx_enabled_r <= 1'b0;
		end else if (en_set_hw | rx_en_set) begin
			rx_enabled_r <= 1'b1;
		end else if (en_clr_hw | rx_en_clr) begin
			rx_enabled_r <= 1'b0;
		end
	end

	// line status interrupt; a new event wins over the clear
	always @(posedge clk) begin
		if (rst) begin
			line_irq_r <= 1'b0;
		end else if (irq_evt & line_ie) begin
			line_irq_r <= 1'b1;
		end else if (line_irq_clr) begin
			line_irq_r <= 1'b0;
		end
	end

	// discard indicator for characters the filter drops
	always @(posedge clk) begin
		if (rst) begin
			dropped_r <= 1'b0;
		end else begin
			dropped_r <= rx_valid & rx_ready & ~store;
		end
	end

	// ==========================================
	// receive fifo and registered head
	wire f_in_ready;
	wire f_out_valid;
	wire [8:0] f_out_data;
	wire f_pop;
	assign rx_ready = f_in_ready;
	// head register refills when empty or when the host pops it
	assign f_pop = f_out_valid & (~fifo_valid_r | fifo_pop);

	rdm_fifo #(
		.WIDTH(`RDM_FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(store),
		.in_ready(f_in_ready),
		.in_data({store_par, rx_data}),
		.out_valid(f_out_valid),
		.out_ready(f_pop),
		.out_data(f_out_data),
		.empty(),
		.full()
	);

	always @(posedge clk) begin
		if (rst) begin
			fifo_valid_r <= 1'b0;
			fifo_data_r <= 8'h00;
			fifo_lsr_par_r <= 1'b0;
		end else if (f_pop) begin
			fifo_valid_r <= 1'b1;
			fifo_data_r <= f_out_data[7:0];
			fifo_lsr_par_r <= f_out_data[8];
		end else if (fifo_pop) begin
			fifo_valid_r <= 1'b0;
		end
	end
endmodule

// >>> tb/rdm_station.sv
// station model: puts one 9-bit character on the receive side
// assumes send, sd and sp from the bench, sampled on the rising edge
`timescale 1ns/1ps
// ====
module rdm_station (
	input wire clk, // clock
	input wire rst, // reset
	input wire send, // emit one character
	input wire [7:0] sd, // character
	input wire sp, // ninth bit
	output reg rx_valid, // strobe
	output reg [7:0] rx_data, // character
	output reg rx_par_bit, // ninth bit
	output reg rx_par_err // parity check
);
	// idle lines show the inverse of the last value so stale data never matches
	always @(posedge clk) begin
		rx_valid <= send && !rst;
		rx_data <= (send || rst) ? sd : ~rx_data;
		rx_par_bit <= (send || rst) ? sp : ~rx_par_bit;
		rx_par_err <= send && sp;
	end
endmodule

// >>> tb/rdm_top_properties.sv
// port assertions for the rs-485 block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
// ====
module rdm_props (
	input wire clk, // clock
	input wire rst, // reset
	input wire [7:0] extra_feature_ctrl_reg, // cfg
	input wire [7:0] enhanced_feature_reg, // cfg
	input wire [7:0] modem_control_reg, // cfg
	input wire [7:0] interrupt_enable_reg, // cfg
	input wire [7:0] address_match_char, // cfg
	input wire hw_flow_en, // in
	input wire tx_write, // in
	input wire tx_fifo_empty, // in
	input wire tx_shift_empty, // in
	input wire rx_valid, // in
	input wire [7:0] rx_data, // in
	input wire rx_par_bit, // in
	input wire rx_ready, // out
	input wire rx_en_set, // in
	input wire rx_enabled_r, // out
	input wire fifo_valid_r, // out
	input wire [7:0] fifo_data_r, // out
	input wire fifo_lsr_par_r, // out
	input wire line_irq_r, // out
	input wire line_irq_clr, // in
	input wire rts_n_r, // out
	input wire dropped_r // out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// accepted character and its filter verdicts
	wire take = rx_valid && rx_ready;
	wire md = extra_feature_ctrl_reg[0];
	wire spc = enhanced_feature_reg[5];
	wire hit = rx_data == address_match_char;
	wire [7:0] efc = extra_feature_ctrl_reg;
	// head checks need an empty fifo; the new-address check also needs nothing in flight
	sequence s_new_addr;
		take && md && rx_par_bit && (!spc || hit) && !fifo_valid_r && !$past(rx_valid);
	endsequence
	sequence s_lost_data;
		take && md && !rx_par_bit && !rx_enabled_r && !rx_en_set && !fifo_valid_r;
	endsequence
	a_rts_manual:
	assert property ((!efc[4] && !hw_flow_en && $stable(modem_control_reg))[*3]
		|-> rts_n_r == !modem_control_reg[1]) else $error("rts not manual");
	a_rts_drive:
	assert property (efc[4] && tx_write ##1 $stable(efc)[*2] |-> rts_n_r == efc[5])
		else $error("rts not driven");
	a_rts_release:
	assert property ((efc[4] && $stable(efc) && tx_fifo_empty && tx_shift_empty
		&& !tx_write)[*4] |-> rts_n_r == !efc[5]) else $error("rts not released");
	a_addr_irq:
	assert property (take && md && rx_par_bit && (!spc || hit) && interrupt_enable_reg[2]
		&& !line_irq_clr |=> line_irq_r) else $error("no line irq");
	a_head_store:
	assert property (s_new_addr ##1 !rx_valid |-> ##1 fifo_valid_r && fifo_lsr_par_r
		&& fifo_data_r == $past(rx_data, 2)) else $error("address not stored");
	a_data_drop:
	assert property (s_lost_data ##1 !rx_valid |-> ##1 !fifo_valid_r)
		else $error("data kept");
	a_mismatch_off:
	assert property (take && md && spc && rx_par_bit && !hit && !rx_en_set
		|=> !rx_enabled_r && dropped_r) else $error("mismatch kept");
	a_match_on:
	assert property (take && md && spc && rx_par_bit && hit |=> rx_enabled_r)
		else $error("match not enabled");
endmodule
bind rdm_top rdm_props u_props (.*);

// >>> tb/testbench.sv
// bench: filter rows in one loop, then rts, fifo, irq mask and reset tests
// assumes the station model drives the receive side
`timescale 1ns/1ps
// ====
module testbench;
	logic clk = 0, rst = 1, hw_flow_en = 0, hw_flow_rts = 1, tx_write = 0;
	logic tx_fifo_empty = 1, tx_shift_empty = 1, rx_en_set = 0, rx_en_clr = 0;
	logic fifo_pop = 0, line_irq_clr = 0, send = 0, sp = 0;
	logic [7:0] extra_feature_ctrl_reg = 8'h00, enhanced_feature_reg = 8'h00;
	logic [7:0] modem_control_reg = 8'h00, interrupt_enable_reg = 8'h04, sd = 8'h00;
	logic [7:0] address_match_char = 8'h5A;
	wire rx_valid, rx_par_bit, rx_par_err, rx_ready, rx_enabled_r, fifo_valid_r;
	wire fifo_lsr_par_r, line_irq_r, rts_n_r, dropped_r;
	wire [7:0] rx_data, fifo_data_r;
	int failures = 0, samples_checked = 0;
	// {multidrop, special, enable, ninth bit, stored, enable after, char}
	logic [13:0] rows [10] = '{14'h023C, 14'h2055, 14'h26A1, 14'h2B66, 14'h2FA2,
		14'h375A, 14'h3B77, 14'h3C5B, 14'h3F5A, 14'h3012};
	logic [13:0] r;
	rdm_top uut (.*);
	rdm_station stn (.*);
	always #10 clk = ~clk;
	// all tasks start and end just after a rising edge
	task automatic chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			failures++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		tick(1);
		s = 0;
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// a hang counts as a mismatch
	initial begin
		#100us;
		failures++;
		wrap_up;
	end
	// main sequence
	initial begin
		tick(2);
		rst = 0;
		chk(rts_n_r === 1'b1 && rx_ready === 1'b1 && fifo_valid_r === 1'b0, "reset");
		foreach (rows[i]) begin
			r = rows[i];
			extra_feature_ctrl_reg[0] = r[13];
			enhanced_feature_reg[5] = r[12];
			if (r[11]) pulse(rx_en_set);
			else pulse(rx_en_clr);
			sd = r[7:0];
			sp = r[10];
			pulse(send);
			tick(3);
			chk(fifo_valid_r === r[9] && rx_enabled_r === r[8], "filter");
			chk(line_irq_r === (r[10] & r[9]), "line irq");
			if (r[9]) begin
				chk(fifo_data_r === r[7:0] && fifo_lsr_par_r === r[10], "head");
				pulse(fifo_pop);
			end
			pulse(line_irq_clr);
			$display("row %0d done", i);
		end
		modem_control_reg = 8'h02;
		tick(3);
		chk(rts_n_r === 1'b0, "manual rts");
		hw_flow_en = 1;
		tick(3);
		chk(rts_n_r === 1'b1, "flow rts");
		hw_flow_en = 0;
		for (int v = 0; v < 2; v++) begin
			extra_feature_ctrl_reg = {2'b00, v[0], 1'b1, 4'h0};
			tick(3);
			chk(rts_n_r === !v[0], "auto idle");
			tx_fifo_empty = 0;
			tx_shift_empty = 0;
			pulse(tx_write);
			tick(3);
			chk(rts_n_r === v[0], "auto drive");
			tx_fifo_empty = 1;
			tick(4);
			chk(rts_n_r === v[0], "shift busy");
			tx_shift_empty = 1;
			tick(4);
			chk(rts_n_r === !v[0], "auto release");
			$display("rts polarity %0d done", v);
		end
		// fill past depth with no reader, then drain in order
		extra_feature_ctrl_reg = 8'h00;
		for (int k = 0; k < 17; k++) begin
			sd = k[7:0];
			pulse(send);
			tick(1);
		end
		tick(2);
		chk(rx_ready === 1'b0, "fifo full");
		// sixteen words wait in the fifo and one more in the head register
		for (int k = 0; k < 17; k++) begin
			chk(fifo_valid_r === 1'b1 && fifo_data_r === k[7:0], "fifo order");
			pulse(fifo_pop);
			tick(3);
		end
		chk(fifo_valid_r === 1'b0 && rx_ready === 1'b1, "fifo drained");
		$display("fifo done");
		interrupt_enable_reg = 8'h00;
		// normal multidrop here, so the address is stored rather than filtered
		enhanced_feature_reg = 8'h00;
		extra_feature_ctrl_reg = 8'h01;
		sd = 8'hA5;
		sp = 1;
		pulse(send);
		tick(3);
		chk(line_irq_r === 1'b0 && fifo_lsr_par_r === 1'b1, "irq masked");
		pulse(rx_en_set);
		rst = 1;
		tick(2);
		rst = 0;
		chk(rx_enabled_r === 1'b0 && fifo_valid_r === 1'b0 && rts_n_r === 1'b1, "reset 2");
		$display("reset done");
		wrap_up;
	end
endmodule
